// *** tt_cfg.svh ***
// offsets, field positions, reset values and counts of the timer-two block
`ifndef TT_CFG_SVH
`define TT_CFG_SVH
`define TT_ADDR_W      8
`define TT_DATA_W      32
`define TT_CTRL_OFS    8'hC8
`define TT_CKCTL_OFS   8'hD0
`define TT_RCAP_OFS    8'hD4
`define TT_COUNT_OFS   8'hD8
`define TT_STAT_OFS    8'hDC
`define TT_CTRL_RST    8'h00
`define TT_PRESC_RST   1'b0
`define TT_RCAP_RST    16'h0000
`define TT_COUNT_RST   16'h0000
`define TT_COUNT_MAX   16'hFFFF
`define TT_OVF_BIT     7
`define TT_EXT_BIT     6
`define TT_RXSEL_BIT   5
`define TT_TXSEL_BIT   4
`define TT_EXEN_BIT    3
`define TT_RUN_BIT     2
`define TT_CNT_BIT     1
`define TT_CAP_BIT     0
`define TT_PRESC_BIT   5
`define TT_DIV_SLOW    4'hC
`define TT_DIV_FAST    4'h4
`define TT_DIV_BAUD    4'h2
`define TT_BAUD_LAST   4'hF
`define TT_RESP_OKAY   2'b00
`define TT_RESP_SLVERR 2'b10
`endif

// *** tt_pkg.sv ***
// bus carrier types of the timer-two block
`include "tt_cfg.svh"
package tt_pkg;
   typedef struct packed {
      logic [`TT_ADDR_W-1:0] awaddr;
      logic                  awvalid;
      logic [`TT_DATA_W-1:0] wdata;
      logic [3:0]            wstrb;
      logic                  wvalid;
      logic                  bready;
      logic [`TT_ADDR_W-1:0] araddr;
      logic                  arvalid;
      logic                  rready;
   } tt_axi_req_t;
   typedef struct packed {
      logic                  awready;
      logic                  wready;
      logic [1:0]            bresp;
      logic                  bvalid;
      logic                  arready;
      logic [`TT_DATA_W-1:0] rdata;
      logic [1:0]            rresp;
      logic                  rvalid;
   } tt_axi_rsp_t;
endpackage

// *** tt_edge_sync.sv ***
// two-flop synchronisers with falling-edge detect, one per pin
`timescale 1ns/100ps
module tt_edge_sync #(
   parameter int W = 2
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // pins and edges
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] fall
);
   if (W < 1) $error("tt_edge_sync needs at least one pin");
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      logic meta;
      logic sync;
      logic last;
      // idle-high pins, so reset to one avoids a false edge
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            meta <= 1'b1;
            sync <= 1'b1;
            last <= 1'b1;
         end
         else
         begin
            meta <= pin[i];
            sync <= meta;
            last <= sync;
         end
      end
      assign fall[i] = last & ~sync;
   end
endmodule

// *** tt_prescaler.sv ***
// divide-by-n tick generator for the internal timer clock
`timescale 1ns/100ps
module tt_prescaler #(
   parameter int CNT_W = 4
) (
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // control
   input  wire logic             run,
   input  wire logic [CNT_W-1:0] div_val,
   // tick out
   output logic                  tick
);
   if (CNT_W < 4) $error("tt_prescaler needs four bits for divide by 12");
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             at_end;
   // >= so a smaller divisor taken mid-count still wraps
   assign at_end = (cnt >= div_val - CNT_W'(1));
   assign tick   = run & at_end;
   always_comb
   begin
      next_cnt = cnt;
      if (run)
      begin
         if (at_end)
            next_cnt = '0;
         else
            next_cnt = cnt + CNT_W'(1);
      end
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cnt <= '0;
      else
         cnt <= next_cnt;
   end
endmodule

// *** tt_timer_two.sv ***
// timer-two control logic with AXI4-Lite register slave
// How it works
// - overflow flag set when count overflows from FFFF, to 0000 or to the reload value; software clears it
// - overflow flag never set by an overflow while either uart clock select is one; a software write still sets it
// - writing one to overflow flag raises the timer interrupt request
// - external flag set when trigger falling edge causes capture or reload
// - external flag raises the same request; only software clears it
// - writing one to external flag raises the timer interrupt request
// - rx select one feeds own overflows to uart receiver, else other timer
// - tx select one feeds own overflows to uart transmitter, else other
// - trigger enable and not baud mode: trigger fall captures or reloads
// - trigger enable zero: trigger pin ignored entirely
// - count advances only while run control is one
// - timer mode increments every four or twelve clocks per prescale select
// - baud mode timer increments every two clocks
// - counter select one counts falling edges of event pin
// - capture select one captures on trigger fall when enabled
// - capture select zero reloads on overflow and enabled trigger fall
// - in baud mode capture select ignored, overflow always reloads
// - prescale select zero divides by twelve, one divides by four
// - capture copies low and high count bytes into capture bytes
// - baud overflows reload count and are divided by sixteen for uart
`timescale 1ns/100ps
`include "tt_cfg.svh"
module tt_timer_two
   import tt_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // register bus
   input  tt_pkg::tt_axi_req_t axi_req,
   output tt_pkg::tt_axi_rsp_t axi_rsp,
   // pins
   input  wire logic        trigger_input_pin,
   input  wire logic        event_input_pin,
   // uart side
   input  wire logic        other_timer_ovf,
   output logic             rx_baud_tick,
   output logic             tx_baud_tick,
   // events
   output logic             timer_irq,
   output logic             overflow_pulse
);
   import tt_pkg::*;

   // bus state
   logic                  aw_full;
   logic                  w_full;
   logic [`TT_ADDR_W-1:0] aw_addr;
   logic [`TT_DATA_W-1:0] w_data;
   logic [3:0]            w_strb;
   tt_axi_rsp_t           next_rsp;
   logic                  next_aw_full;
   logic                  next_w_full;
   logic [`TT_ADDR_W-1:0] next_aw_addr;
   logic [`TT_DATA_W-1:0] next_w_data;
   logic [3:0]            next_w_strb;
   logic                  wr_fire;
   logic                  wr_map;
   logic                  rd_map;
   logic [`TT_DATA_W-1:0] rd_data;

   // timer state
   logic [7:0]  ctrl;
   logic        presc;
   logic [15:0] rcap;
   logic [15:0] count;
   logic [3:0]  baud_div;
   logic [7:0]  next_ctrl;
   logic        next_presc;
   logic [15:0] next_rcap;
   logic [15:0] next_count;
   logic [3:0]  next_baud_div;
   logic        next_rx_tick;
   logic        next_tx_tick;

   // decoded conditions
   logic        baud;
   logic        run;
   logic [3:0]  div_val;
   logic        presc_tick;
   logic        trig_fall;
   logic        event_fall;
   logic        inc;
   logic        ovf;
   logic        trig;
   logic        own_tick;
   logic        wr_ctrl;
   logic        wr_ckctl;
   logic        wr_rcap_lo;
   logic        wr_rcap_hi;
   logic        wr_count_lo;
   logic        wr_count_hi;

   tt_edge_sync #(
      .W (2)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     ({event_input_pin, trigger_input_pin}),
      .fall    ({event_fall, trig_fall})
   );

   assign baud    = ctrl[`TT_RXSEL_BIT] | ctrl[`TT_TXSEL_BIT];
   assign run     = ctrl[`TT_RUN_BIT];
   assign div_val = baud  ? `TT_DIV_BAUD :
                    presc ? `TT_DIV_FAST : `TT_DIV_SLOW;

   tt_prescaler #(
      .CNT_W (4)
   ) u_presc (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (run),
      .div_val (div_val),
      .tick    (presc_tick)
   );

   assign inc = run & (ctrl[`TT_CNT_BIT] ? event_fall : presc_tick);
   assign ovf = inc & (count == `TT_COUNT_MAX);
   // trigger qualified by enable and mode
   assign trig     = trig_fall & ctrl[`TT_EXEN_BIT] & ~baud;
   assign own_tick = ovf & baud & (baud_div == `TT_BAUD_LAST);

   // register write strobes
   assign wr_fire     = aw_full & w_full & ~axi_rsp.bvalid;
   assign wr_ctrl     = wr_fire & (aw_addr == `TT_CTRL_OFS) & w_strb[0];
   assign wr_ckctl    = wr_fire & (aw_addr == `TT_CKCTL_OFS) & w_strb[0];
   assign wr_rcap_lo  = wr_fire & (aw_addr == `TT_RCAP_OFS) & w_strb[0];
   assign wr_rcap_hi  = wr_fire & (aw_addr == `TT_RCAP_OFS) & w_strb[1];
   assign wr_count_lo = wr_fire & (aw_addr == `TT_COUNT_OFS) & w_strb[0];
   assign wr_count_hi = wr_fire & (aw_addr == `TT_COUNT_OFS) & w_strb[1];

   always_comb
   begin
      next_ctrl     = ctrl;
      next_presc    = presc;
      next_rcap     = rcap;
      next_count    = count;
      next_baud_div = baud_div;
      // a written one raises the request like hardware
      if (wr_ctrl)
         next_ctrl = w_data[7:0];
      if (ovf && !baud)
         next_ctrl[`TT_OVF_BIT] = 1'b1;
      if (trig)
         next_ctrl[`TT_EXT_BIT] = 1'b1;
      if (wr_ckctl)
         next_presc = w_data[`TT_PRESC_BIT];
      if (wr_rcap_lo)
         next_rcap[7:0] = w_data[7:0];
      if (wr_rcap_hi)
         next_rcap[15:8] = w_data[15:8];
      // capture both bytes, over a software write
      if (trig && ctrl[`TT_CAP_BIT])
         next_rcap = count;
      if (trig && !ctrl[`TT_CAP_BIT])
         next_count = rcap;
      else if (ovf && (baud || !ctrl[`TT_CAP_BIT]))
         next_count = rcap;
      else if (inc)
         next_count = count + 16'h0001;
      // software write to the count wins; it is a value, not a flag
      if (wr_count_lo)
         next_count[7:0] = w_data[7:0];
      if (wr_count_hi)
         next_count[15:8] = w_data[15:8];
      if (ovf && baud)
         next_baud_div = baud_div + 4'h1;
      next_rx_tick = ctrl[`TT_RXSEL_BIT] ? own_tick : other_timer_ovf;
      next_tx_tick = ctrl[`TT_TXSEL_BIT] ? own_tick : other_timer_ovf;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl           <= `TT_CTRL_RST;
         presc          <= `TT_PRESC_RST;
         rcap           <= `TT_RCAP_RST;
         count          <= `TT_COUNT_RST;
         baud_div       <= 4'h0;
         rx_baud_tick   <= 1'b0;
         tx_baud_tick   <= 1'b0;
         timer_irq      <= 1'b0;
         overflow_pulse <= 1'b0;
      end
      else
      begin
         ctrl           <= next_ctrl;
         presc          <= next_presc;
         rcap           <= next_rcap;
         count          <= next_count;
         baud_div       <= next_baud_div;
         rx_baud_tick   <= next_rx_tick;
         tx_baud_tick   <= next_tx_tick;
         timer_irq      <= next_ctrl[`TT_OVF_BIT] | next_ctrl[`TT_EXT_BIT];
         overflow_pulse <= ovf;
      end
   end

   // read mux and address decode
   always_comb
   begin
      rd_data = '0;
      rd_map  = 1'b1;
      case (axi_req.araddr)
         `TT_CTRL_OFS:  rd_data[7:0] = ctrl;
         `TT_CKCTL_OFS: rd_data[`TT_PRESC_BIT] = presc;
         `TT_RCAP_OFS:  rd_data[15:0] = rcap;
         `TT_COUNT_OFS: rd_data[15:0] = count;
         `TT_STAT_OFS:  rd_data[4:0] = {baud_div, baud};
         default:       rd_map = 1'b0;
      endcase
   end

   // status register is read-only; writes to it are accepted and dropped
   assign wr_map = (aw_addr == `TT_CTRL_OFS) || (aw_addr == `TT_CKCTL_OFS) ||
                   (aw_addr == `TT_RCAP_OFS) || (aw_addr == `TT_COUNT_OFS) ||
                   (aw_addr == `TT_STAT_OFS);

   always_comb
   begin
      next_rsp     = axi_rsp;
      next_aw_full = aw_full;
      next_w_full  = w_full;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      if (axi_req.awvalid && axi_rsp.awready)
      begin
         next_aw_full = 1'b1;
         next_aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready)
      begin
         next_w_full = 1'b1;
         next_w_data = axi_req.wdata;
         next_w_strb = axi_req.wstrb;
      end
      if (axi_rsp.bvalid && axi_req.bready)
         next_rsp.bvalid = 1'b0;
      if (wr_fire)
      begin
         next_aw_full   = 1'b0;
         next_w_full    = 1'b0;
         next_rsp.bvalid = 1'b1;
         next_rsp.bresp  = wr_map ? `TT_RESP_OKAY : `TT_RESP_SLVERR;
      end
      next_rsp.awready = ~next_aw_full;
      next_rsp.wready  = ~next_w_full;
      if (axi_rsp.rvalid && axi_req.rready)
         next_rsp.rvalid = 1'b0;
      if (axi_req.arvalid && axi_rsp.arready)
      begin
         next_rsp.rvalid = 1'b1;
         next_rsp.rdata  = rd_data;
         next_rsp.rresp  = rd_map ? `TT_RESP_OKAY : `TT_RESP_SLVERR;
      end
      next_rsp.arready = ~next_rsp.rvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         axi_rsp         <= '0;
         axi_rsp.awready <= 1'b1;
         axi_rsp.wready  <= 1'b1;
         axi_rsp.arready <= 1'b1;
         aw_full         <= 1'b0;
         w_full          <= 1'b0;
         aw_addr         <= '0;
         w_data          <= '0;
         w_strb          <= 4'h0;
      end
      else
      begin
         axi_rsp <= next_rsp;
         aw_full <= next_aw_full;
         w_full  <= next_w_full;
         aw_addr <= next_aw_addr;
         w_data  <= next_w_data;
         w_strb  <= next_w_strb;
      end
   end

   // helper: cycles between prescaler ticks at a steady divisor
   logic [3:0] gap;
   logic       gap_ok;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gap    <= 4'h0;
         gap_ok <= 1'b0;
      end
      else
      begin
         gap    <= presc_tick ? 4'h0 : (run ? gap + 4'h1 : gap);
         gap_ok <= (presc_tick | gap_ok) & run & (div_val == next_div_c());
      end
   end
   function automatic logic [3:0] next_div_c();
      next_div_c = (next_ctrl[`TT_RXSEL_BIT] | next_ctrl[`TT_TXSEL_BIT]) ?
                   `TT_DIV_BAUD : (next_presc ? `TT_DIV_FAST : `TT_DIV_SLOW);
   endfunction

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ovf_flag_set_a: assert property (ovf && !baud |=> ctrl[`TT_OVF_BIT])
      else $error("overflow did not set flag");
   baud_no_flag_a: assert property (baud && !wr_ctrl &&
      !ctrl[`TT_OVF_BIT] |=> !ctrl[`TT_OVF_BIT])
      else $error("overflow flag set in baud mode");
   irq_tracks_flags_a: assert property (##1 timer_irq ==
      (ctrl[`TT_OVF_BIT] | ctrl[`TT_EXT_BIT]))
      else $error("interrupt request disagrees with flags");
   ext_flag_set_a: assert property (trig |=> ctrl[`TT_EXT_BIT])
      else $error("trigger did not set external flag");
   trig_ignored_a: assert property (trig_fall && !ctrl[`TT_EXEN_BIT] &&
      !wr_ctrl && !ctrl[`TT_EXT_BIT] && !wr_rcap_lo && !wr_rcap_hi
      |=> !ctrl[`TT_EXT_BIT] && $stable(rcap))
      else $error("disabled trigger had an effect");
   // stopped count holds
   // a stopped timer still takes a trigger reload, never an increment
   run_hold_a: assert property (!run && !wr_count_lo && !wr_count_hi
      |=> count == (($past(trig) && !$past(ctrl[`TT_CAP_BIT])) ?
      $past(rcap) : $past(count)))
      else $error("count moved while stopped");
   capture_copy_a: assert property (trig && ctrl[`TT_CAP_BIT]
      |=> rcap == $past(count))
      else $error("capture value wrong");
   ovf_reload_a: assert property (ovf && (baud || !ctrl[`TT_CAP_BIT]) &&
      !wr_count_lo && !wr_count_hi |=> count == $past(rcap))
      else $error("overflow did not reload");
   tick_spacing_a: assert property (presc_tick && gap_ok
      |-> gap == div_val - 4'h1)
      else $error("prescaler tick spacing wrong");
   rx_source_a: assert property (ctrl[`TT_RXSEL_BIT] && own_tick
      |=> rx_baud_tick)
      else $error("receiver missed own baud tick");
   tx_source_a: assert property (!ctrl[`TT_TXSEL_BIT] && other_timer_ovf
      |=> tx_baud_tick)
      else $error("transmitter missed other timer tick");

   ovf_seen_c: cover property (ovf && !baud ##1 timer_irq);
   capture_seen_c: cover property (trig && ctrl[`TT_CAP_BIT]);
   baud_tick_c: cover property (own_tick);
   write_done_c: cover property (wr_fire ##1 axi_rsp.bvalid);
endmodule

// *** tt_far_end.sv ***
// far-side model: trigger and event pins, other timer overflow
`timescale 1ns/100ps
module tt_far_end #(
   parameter int OTH_P = 7
) (
   // clock
   input  wire logic aclk,
   // pins and uart clock source
   output logic      trigger_input_pin,
   output logic      event_input_pin,
   output logic      other_timer_ovf
);
   int ph;
   // pins idle high, as the port pull-ups leave them
   initial
   begin
      trigger_input_pin = 1'b1;
      event_input_pin = 1'b1;
      other_timer_ovf = 1'b0;
      ph = 0;
   end
   // free-running overflow pulse of the other timer
   always @(posedge aclk)
   begin
      ph <= (ph == OTH_P - 1) ? 0 : ph + 1;
      other_timer_ovf <= (ph == OTH_P - 1);
   end
   // slow falls, so the two-flop sync never misses one
   task automatic pulse(input bit which, input int n);
      repeat (n)
      begin
         @(posedge aclk);
         if (which)
            event_input_pin <= 1'b0;
         else
            trigger_input_pin <= 1'b0;
         repeat (4) @(posedge aclk);
         event_input_pin <= 1'b1;
         trigger_input_pin <= 1'b1;
         repeat (3) @(posedge aclk);
      end
   endtask
endmodule

// *** tb.sv ***
// self-checking bench of the timer-two block
`timescale 1ns/100ps
`include "tt_cfg.svh"
module tb;
   import tt_pkg::*;
   localparam int OTH_P = 7;
   logic        aclk;
   logic        aresetn;
   tt_axi_req_t req;
   tt_axi_rsp_t rsp;
   logic        trig;
   logic        evt;
   logic        oth;
   logic        rx_t;
   logic        tx_t;
   logic        irq;
   logic        ovf;
   logic [2:0]  outs;
   int          error_cnt;
   int          n_tests;
   int          nn;
   int          per;
   int          i;
   logic [31:0] cv;
   logic [31:0] d;
   logic [31:0] m_cnt;
   logic [31:0] m_rc;
   logic [1:0]  rs;
   logic        act;
   logic [7:0]  tbl [4] = '{8'h09, 8'h01, 8'h08, 8'h28};

   assign outs = {tx_t, rx_t, ovf};

   tt_timer_two DUT (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .axi_req           (req),
      .axi_rsp           (rsp),
      .trigger_input_pin (trig),
      .event_input_pin   (evt),
      .other_timer_ovf   (oth),
      .rx_baud_tick      (rx_t),
      .tx_baud_tick      (tx_t),
      .timer_irq         (irq),
      .overflow_pulse    (ovf)
   );

   tt_far_end #(.OTH_P(OTH_P)) far (
      .aclk              (aclk),
      .trigger_input_pin (trig),
      .event_input_pin   (evt),
      .other_timer_ovf   (oth)
   );

   initial
      aclk = 1'b0;
   always #25 aclk = ~aclk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask

   // write: address and data offered together, bready held until bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     input logic [1:0] er);
      int k;
      @(posedge aclk);
      req.awaddr <= a;
      req.wdata <= v;
      req.wstrb <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      for (k = 0; k < 100; k++)
      begin
         @(posedge aclk);
         if (req.awvalid && rsp.awready)
            req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready)
            req.wvalid <= 1'b0;
         if (rsp.bvalid)
            break;
      end
      req.bready <= 1'b0;
      chk(k < 100, 1'b1);
      chk(rsp.bresp, er);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] r);
      int k;
      @(posedge aclk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      for (k = 0; k < 100; k++)
      begin
         @(posedge aclk);
         if (req.arvalid && rsp.arready)
            req.arvalid <= 1'b0;
         if (rsp.rvalid)
            break;
      end
      req.rready <= 1'b0;
      v = rsp.rdata;
      r = rsp.rresp;
      chk(k < 100, 1'b1);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      logic [1:0]  r;
      rd(a, v, r);
      chk(v, e);
      chk(r, `TT_RESP_OKAY);
   endtask

   // spacing of the last two of three pulses; the first may be irregular
   task automatic period(input int sel, output int p);
      int k;
      int t;
      int h;
      h = 0;
      t = 0;
      p = -1;
      for (k = 0; k < 3000; k++)
      begin
         @(posedge aclk);
         if (outs[sel] === 1'b1)
         begin
            h++;
            if (h == 3)
            begin
               p = k - t;
               break;
            end
            t = k;
         end
      end
   endtask

   task automatic wrap_up();
      $display("mismatches %0d in %0d checks", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // watchdog, well beyond the few thousand cycles the run needs
   initial
   begin
      repeat (60000) @(posedge aclk);
      error_cnt++;
      wrap_up();
   end

   initial
   begin
      req = '0;
      aresetn = 1'b0;
      error_cnt = 0;
      n_tests = 0;
      void'($urandom(32'h77AAB945));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rdchk(`TT_CTRL_OFS, 32'h0);
      rdchk(`TT_CKCTL_OFS, 32'h0);
      rdchk(`TT_RCAP_OFS, 32'h0);
      rdchk(`TT_COUNT_OFS, 32'h0);
      chk({irq, outs}, 4'h0);
      rd(8'hE0, d, rs);
      chk(d, 32'h0);
      chk(rs, `TT_RESP_SLVERR);
      wr(8'hE0, 32'hFF, `TT_RESP_SLVERR);
      // status is read-only: a write is accepted and dropped
      wr(`TT_STAT_OFS, 32'hFF, `TT_RESP_OKAY);
      rdchk(`TT_STAT_OFS, 32'h0);
      // flags written by software
      for (i = 0; i < 2; i++)
      begin
         wr(`TT_CTRL_OFS, i ? 32'h40 : 32'h80, `TT_RESP_OKAY);
         repeat (2) @(posedge aclk);
         chk(irq, 1'b1);
         wr(`TT_CTRL_OFS, 32'h0, `TT_RESP_OKAY);
         repeat (2) @(posedge aclk);
         chk(irq, 1'b0);
      end
      // timer rates from a short reload span
      nn = 2 + $urandom % 5;
      m_rc = 32'h10000 - nn;
      wr(`TT_RCAP_OFS, m_rc, `TT_RESP_OKAY);
      // start inside the reload span, else the first wrap is far off
      wr(`TT_COUNT_OFS, m_rc, `TT_RESP_OKAY);
      for (i = 0; i < 2; i++)
      begin
         wr(`TT_CKCTL_OFS, i << `TT_PRESC_BIT, `TT_RESP_OKAY);
         wr(`TT_CTRL_OFS, 32'h04, `TT_RESP_OKAY);
         period(0, per);
         chk(per, nn * (i ? 4 : 12));
         rdchk(`TT_CTRL_OFS, 32'h84);
         chk(irq, 1'b1);
         wr(`TT_CTRL_OFS, 32'h0, `TT_RESP_OKAY);
      end
      wr(`TT_COUNT_OFS, 32'h1234, `TT_RESP_OKAY);
      repeat (30) @(posedge aclk);
      rdchk(`TT_COUNT_OFS, 32'h1234);
      wr(`TT_COUNT_OFS, m_rc, `TT_RESP_OKAY);
      // baud generation, rx then tx on own overflows
      for (i = 0; i < 2; i++)
      begin
         cv = i ? 32'h14 : 32'h25;
         wr(`TT_CTRL_OFS, cv, `TT_RESP_OKAY);
         period(0, per);
         chk(per, 2 * nn);
         period(i ? 2 : 1, per);
         chk(per, 32 * nn);
         period(i ? 1 : 2, per);
         chk(per, OTH_P);
         rdchk(`TT_CTRL_OFS, cv);
         wr(`TT_CTRL_OFS, 32'h0, `TT_RESP_OKAY);
      end
      // trigger pin: capture, ignored, reload, baud-blocked
      for (i = 0; i < 4; i++)
      begin
         cv = tbl[i];
         m_cnt = $urandom & 32'hFFFF;
         m_rc = $urandom & 32'hFFFF;
         wr(`TT_RCAP_OFS, m_rc, `TT_RESP_OKAY);
         wr(`TT_COUNT_OFS, m_cnt, `TT_RESP_OKAY);
         wr(`TT_CTRL_OFS, cv, `TT_RESP_OKAY);
         far.pulse(1'b0, 1);
         repeat (4) @(posedge aclk);
         act = cv[`TT_EXEN_BIT] && !(cv[`TT_RXSEL_BIT] || cv[`TT_TXSEL_BIT]);
         if (act && cv[`TT_CAP_BIT])
            m_rc = m_cnt;
         else if (act)
            m_cnt = m_rc;
         rdchk(`TT_COUNT_OFS, m_cnt);
         rdchk(`TT_RCAP_OFS, m_rc);
         rdchk(`TT_CTRL_OFS, cv | (act << `TT_EXT_BIT));
         chk(irq, act);
         wr(`TT_CTRL_OFS, 32'h0, `TT_RESP_OKAY);
      end
      // event counting across a wrap with reload
      m_rc = $urandom & 32'h7FFF;
      wr(`TT_RCAP_OFS, m_rc, `TT_RESP_OKAY);
      wr(`TT_COUNT_OFS, 32'hFFFD, `TT_RESP_OKAY);
      wr(`TT_CTRL_OFS, 32'h06, `TT_RESP_OKAY);
      far.pulse(1'b1, 5);
      repeat (4) @(posedge aclk);
      rdchk(`TT_COUNT_OFS, m_rc + 2);
      rdchk(`TT_CTRL_OFS, 32'h86);
      wr(`TT_CTRL_OFS, 32'h02, `TT_RESP_OKAY);
      far.pulse(1'b1, 3);
      repeat (4) @(posedge aclk);
      rdchk(`TT_COUNT_OFS, m_rc + 2);
      wrap_up();
   end
endmodule
